// ### verilog/sdf_regs.svh
// Constants of the sinc-cubed decimation filter: rates, widths, settling.
// Assumes inclusion by bare name from the rate generator and filter design files.
//
// Behaviour
// (RULE1) Modulator strobe runs at clock rate times rate multiplier over 512.
// (RULE2) Capacitor switch strobe runs at clock times multiplier times gain over 512.
// (RULE3) Output words appear at modulator rate over decimation ratio plus one.
// (RULE4) Samples per output follow the programmed decimation ratio.
// (RULE5) Each word uses results from the last three output periods.
// (RULE6) Response is sinc cubed with N the decimation length.
// (RULE7) Filter averages the bits, giving nulls at data rate multiples.
// (RULE8) Half-power point follows at 0.262 times data rate from sinc cubed.
// (RULE9) Positive differential input yields positive signed two's complement words.
// (RULE10) Rate multiplier supports 1, 2, 4, 8 and 16.
// (RULE11) Each word spans three ratios of samples; settles after three words.
// (RULE12) Three integrators at modulator rate, three differentiators at output rate.
// (RULE13) A valid pulse marks each new word once per output period.
`ifndef SDF_REGS_SVH
`define SDF_REGS_SVH

// ****************************************************************
// Rate generation
// ****************************************************************
`define SDF_PHASE_W     9
`define SDF_MOD_DIV     10'h200
`define SDF_SEL_MAX     3'h4
`define SDF_GAP_W       10
`define SDF_GAP_ONE     10'h001

// ****************************************************************
// Filter structure
// ****************************************************************
`define SDF_ORDER       3
`define SDF_SETTLE_CNT  2'h3
`define SDF_WORD_INC    2'h1

`endif

// ### verilog/sdf_pkg.sv
// Types shared by the decimation filter modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sdf_pkg;
  typedef logic [2:0] sdf_sel_t;
endpackage
`default_nettype wire

// ### verilog/sdf_rate_if.sv
// Strobes and rate selections passed between rate generator and filter.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface sdf_rate_if;
  sdf_pkg::sdf_sel_t turboSel;
  sdf_pkg::sdf_sel_t gainSel;
  logic              modStb;
  logic              capStb;

  modport gen (input turboSel, input gainSel, output modStb, output capStb);
  modport flt (output turboSel, output gainSel, input modStb, input capStb);
endinterface
`default_nettype wire

// ### verilog/sdf_rate_gen.sv
// Phase accumulators that derive modulator and capacitor strobes.
// Assumes selections stay steady for at least one strobe period.
`timescale 1ns/100ps
`default_nettype none
`include "sdf_regs.svh"
module sdf_rate_gen
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Selections in, strobes out.
  sdf_rate_if.gen  rif
);

  typedef struct packed
  {
    logic [1:0][`SDF_PHASE_W-1:0] ph;
    logic [1:0]                   stb;
  } sdf_rg_s;

  sdf_rg_s            st_r;
  sdf_rg_s            st_nxt;
  sdf_pkg::sdf_sel_t  tSel;
  sdf_pkg::sdf_sel_t  gSel;

  // ****************************************************************
  // Accumulators
  // ****************************************************************
  // Selections beyond sixteen clamp, so a bad code never stalls the rate.
  always_comb
  begin
    logic [1:0][`SDF_PHASE_W:0] sum;
    logic [`SDF_PHASE_W:0]      inc;
    sum    = '0;
    inc    = '0;
    tSel   = (rif.turboSel > `SDF_SEL_MAX) ? `SDF_SEL_MAX : rif.turboSel;
    gSel   = (rif.gainSel > `SDF_SEL_MAX) ? `SDF_SEL_MAX : rif.gainSel;
    st_nxt = st_r;
    for (int k = 0; k < 2; k++)
    begin
      // Step is the multiplier, times gain for the capacitor lane.
      inc    = `SDF_GAP_ONE << tSel; // RULE10
      if (k == 1)
        inc = inc << gSel; // RULE2
      sum[k] = {1'b0, st_r.ph[k]} + inc;
      st_nxt.ph[k]  = sum[k][`SDF_PHASE_W-1:0];
      st_nxt.stb[k] = sum[k][`SDF_PHASE_W]; // RULE1 RULE2
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rif.modStb = st_r.stb[0];
  assign rif.capStb = st_r.stb[1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Gap counters measure cycles between strobes under steady selections.
  logic [1:0][`SDF_GAP_W-1:0] gap_r;
  logic [1:0]                 seen_r;
  logic [5:0]                 selPrev_r;
  sdf_pkg::sdf_sel_t          tPrev;
  sdf_pkg::sdf_sel_t          gPrev;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_r     <= '0;
      seen_r    <= '0;
      selPrev_r <= '0;
    end
    else
    begin
      selPrev_r <= {tSel, gSel};
      for (int k = 0; k < 2; k++)
      begin
        gap_r[k] <= st_r.stb[k] ? `SDF_GAP_ONE : gap_r[k] + `SDF_GAP_ONE;
        if ({tSel, gSel} != selPrev_r)
          seen_r[k] <= 1'b0;
        else if (st_r.stb[k])
          seen_r[k] <= 1'b1;
      end
    end
  end

  // A strobe was computed one cycle before it shows, so it is judged by
  // the selections of that cycle; a change on the strobe cycle is legal.
  assign {tPrev, gPrev} = selPrev_r;

  property p_mod_gap;
    @(posedge clk) disable iff (!resetn)
    (st_r.stb[0] && seen_r[0]) |-> (gap_r[0] == (`SDF_MOD_DIV >> tPrev));
  endproperty
  a_mod_gap: assert property (p_mod_gap) // RULE1
    else $error("Modulator strobe spacing wrong.");

  property p_cap_gap;
    @(posedge clk) disable iff (!resetn)
    (st_r.stb[1] && seen_r[1])
      |-> (gap_r[1] == ((`SDF_MOD_DIV >> tPrev) >> gPrev));
  endproperty
  a_cap_gap: assert property (p_cap_gap) // RULE2
    else $error("Capacitor strobe spacing wrong.");

endmodule // sdf_rate_gen
`default_nettype wire

// ### verilog/sdf_sinc3_filter.sv
// Top of the sinc-cubed decimation filter of a delta-sigma converter.
// Assumes the modulator bit is valid in the cycle of modStrobe and that
// the serial side takes dataWord on the dataValid pulse.
`timescale 1ns/100ps
`default_nettype none
`include "sdf_regs.svh"
module sdf_sinc3_filter
#(
  parameter int DR_W  = 13,
  parameter int ACC_W = 3 * (DR_W + 1) + 1
)
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             resetn,
  // Configuration from the command side.
  input  wire logic [2:0]       turboSel,
  input  wire logic [2:0]       inputGainSetting,
  input  wire logic [DR_W-1:0]  decimRatio,
  // Modulator side.
  input  wire logic             modBit,
  output logic                  modulatorRate,
  output logic                  capacitorSwitchRate,
  // Result side.
  output logic signed [ACC_W-1:0] dataWord,
  output logic                  dataValid,
  output logic                  dataSettled
);

  // ****************************************************************
  // Rate generation
  // ****************************************************************
  sdf_rate_if rif ();
  assign rif.turboSel = turboSel;
  assign rif.gainSel  = inputGainSetting;

  sdf_rate_gen u_rate
  (
    .clk    (clk),
    .resetn (resetn),
    .rif    (rif)
  );

  // Both strobes leave straight from the generator's flip-flops.
  assign modulatorRate       = rif.modStb; // RULE1
  assign capacitorSwitchRate = rif.capStb; // RULE2

  // ****************************************************************
  // Filter state
  // ****************************************************************
  typedef logic signed [ACC_W-1:0] sdf_acc_t;
  typedef struct packed
  {
    logic [DR_W-1:0]                 cnt;
    sdf_acc_t [`SDF_ORDER-1:0]       integ;
    sdf_acc_t [`SDF_ORDER-1:0]       dly;
    sdf_acc_t                        word;
    logic                            valid;
    logic [1:0]                      words;
    logic                            settled;
  } sdf_flt_s;

  sdf_flt_s st_r;
  sdf_flt_s st_nxt;
  logic     wrap;
  sdf_acc_t sample;

  // A one maps to plus one, a zero to minus one, so the average carries
  // the sign of the differential input.
  assign sample = modBit ? sdf_acc_t'(1) : sdf_acc_t'(-1); // RULE9
  assign wrap   = rif.modStb && (st_r.cnt == '0);

  // ****************************************************************
  // Integrators, decimation and differentiators
  // ****************************************************************
  // Integrators wrap modulo two to the ACC_W; the differentiators undo
  // the wrap exactly, which is why no saturation is needed anywhere.
  always_comb
  begin
    sdf_acc_t x;
    sdf_acc_t y;
    x      = '0;
    y      = '0;
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    if (rif.modStb)
    begin
      // Cascade of three running sums at the modulator rate.
      x = sample;
      for (int k = 0; k < `SDF_ORDER; k++)
      begin
        st_nxt.integ[k] = st_r.integ[k] + x; // RULE12 RULE7
        x = st_nxt.integ[k];
      end
      // Count down and reload from the ratio, N = ratio plus one.
      if (st_r.cnt == '0)
        st_nxt.cnt = decimRatio; // RULE4 RULE12
      else
        st_nxt.cnt = st_r.cnt - 1'b1; // RULE4
    end
    if (wrap)
    begin
      // Three differences, each against its value one period back, so
      // the word spans three periods of samples: sinc cubed of length N.
      x = st_nxt.integ[`SDF_ORDER-1];
      for (int k = 0; k < `SDF_ORDER; k++)
      begin
        y = x - st_r.dly[k]; // RULE5 RULE6 RULE8
        st_nxt.dly[k] = x;
        x = y;
      end
      st_nxt.word  = x; // RULE7 RULE9
      st_nxt.valid = 1'b1; // RULE3 RULE13
      // The first words mix in reset history; the flag rises on the third.
      if (st_r.words != `SDF_SETTLE_CNT)
        st_nxt.words = st_r.words + `SDF_WORD_INC; // RULE11
      st_nxt.settled = (st_nxt.words == `SDF_SETTLE_CNT); // RULE11
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dataWord    = st_r.word;
  assign dataValid   = st_r.valid;
  assign dataSettled = st_r.settled;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_wrap;
    rif.modStb && (st_r.cnt == '0);
  endsequence

  sequence s_count;
    rif.modStb && (st_r.cnt != '0);
  endsequence

  property p_valid_on_wrap;
    @(posedge clk) disable iff (!resetn)
    s_wrap |=> dataValid ##1 !dataValid;
  endproperty
  a_valid_on_wrap: assert property (p_valid_on_wrap) // RULE13
    else $error("Valid pulse missing after wrap.");

  property p_valid_only_on_wrap;
    @(posedge clk) disable iff (!resetn)
    dataValid |-> $past(wrap);
  endproperty
  a_valid_only_on_wrap: assert property (p_valid_only_on_wrap) // RULE3
    else $error("Valid pulse without wrap.");

  property p_reload;
    @(posedge clk) disable iff (!resetn)
    s_wrap |=> (st_r.cnt == $past(decimRatio));
  endproperty
  a_reload: assert property (p_reload) // RULE12
    else $error("Counter did not reload from the ratio.");

  property p_count_down;
    @(posedge clk) disable iff (!resetn)
    s_count |=> (st_r.cnt == $past(st_r.cnt) - 1'b1);
  endproperty
  a_count_down: assert property (p_count_down) // RULE4
    else $error("Counter did not step down.");

  property p_integrate;
    @(posedge clk) disable iff (!resetn)
    rif.modStb |=> (st_r.integ[0] == $past(st_r.integ[0]) + $past(sample));
  endproperty
  a_integrate: assert property (p_integrate) // RULE12
    else $error("First integrator missed a sample.");

  property p_history;
    @(posedge clk) disable iff (!resetn)
    s_wrap |=> (st_r.dly[0] == st_r.integ[`SDF_ORDER-1])
               && dataValid;
  endproperty
  a_history: assert property (p_history) // RULE5
    else $error("Differentiator history not captured.");

  property p_settle;
    @(posedge clk) disable iff (!resetn)
    (dataValid && !$past(dataSettled) && dataSettled)
      |-> (st_r.words == `SDF_SETTLE_CNT);
  endproperty
  a_settle: assert property (p_settle) // RULE11
    else $error("Settled flag rose at the wrong word.");

  // A strobe lasts one cycle, so no modulator bit is ever taken twice.
  property p_strobe_single;
    @(posedge clk) disable iff (!resetn)
    rif.modStb |=> !rif.modStb;
  endproperty
  a_strobe_single: assert property (p_strobe_single) // RULE1
    else $error("Modulator strobe longer than one cycle.");

  // Between strobes the integrators must hold, or the sum runs too fast.
  property p_integ_hold;
    @(posedge clk) disable iff (!resetn)
    !rif.modStb |=> $stable(st_r.integ);
  endproperty
  a_integ_hold: assert property (p_integ_hold) // RULE12
    else $error("Integrators moved without a strobe.");

  // The word stands unchanged until the next valid pulse announces one.
  property p_word_holds;
    @(posedge clk) disable iff (!resetn)
    !dataValid |-> $stable(dataWord);
  endproperty
  a_word_holds: assert property (p_word_holds) // RULE13
    else $error("Result word changed without a valid pulse.");

  // Once settled, the flag stays up until the next reset.
  property p_settled_holds;
    @(posedge clk) disable iff (!resetn)
    dataSettled |=> dataSettled;
  endproperty
  a_settled_holds: assert property (p_settled_holds) // RULE11
    else $error("Settled flag dropped before reset.");

endmodule // sdf_sinc3_filter
`default_nettype wire

// ### dv/sdf_mod_model.sv
// Modulator stand-in: hands the filter one bit per modulator strobe.
// Assumes the filter's strobe output and the bench clock.
`timescale 1ns/100ps
`default_nettype none
module sdf_mod_model
(
  // Clock and strobe from the filter.
  input  wire logic       clk,
  input  wire logic       modStb,
  // Bit pattern: 0 all low, 1 all high, 2 or 3 alternating.
  input  wire logic [1:0] pattern,
  output logic            modBit
);
  logic toggle_r = 1'b0;

  // Step the alternating pattern once per strobe.
  always_ff @(posedge clk)
  begin
    if (modStb)
      toggle_r <= ~toggle_r;
  end

  // Outside a strobe the bit is inverted, so a filter that samples at
  // the wrong moment sees garbage rather than a lucky match.
  assign modBit = modStb ~^ (pattern[1] ? toggle_r : pattern[0]);
endmodule // sdf_mod_model
`default_nettype wire

// ### dv/sdf_sinc3_filter_tb.sv
// Self-checking bench of the sinc-cubed decimation filter.
// Assumes the modulator model file is compiled beforehand.
`timescale 1ns/100ps
`default_nettype none
module sdf_sinc3_filter_tb;
  localparam int DR_W  = 13;
  localparam int ACC_W = 3 * (DR_W + 1) + 1;
  logic                    clk, resetn, modBit, modRate, capRate;
  logic                    dataValid, dataSettled;
  logic [2:0]              turboSel, gainSel, pulses;
  logic [1:0]              pattern;
  logic [DR_W-1:0]         decimRatio;
  logic signed [ACC_W-1:0] dataWord;
  int                      num_errors = 0;
  int                      n_checks = 0;

  // ****************************************************************
  // Clock, design and modulator
  // ****************************************************************
  // The 8 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  sdf_sinc3_filter #(.DR_W(DR_W)) uut
  (
    .clk                 (clk),
    .resetn              (resetn),
    .turboSel            (turboSel),
    .inputGainSetting    (gainSel),
    .decimRatio          (decimRatio),
    .modBit              (modBit),
    .modulatorRate       (modRate),
    .capacitorSwitchRate (capRate),
    .dataWord            (dataWord),
    .dataValid           (dataValid),
    .dataSettled         (dataSettled)
  );

  sdf_mod_model modulator
  (
    .clk     (clk),
    .modStb  (modRate),
    .pattern (pattern),
    .modBit  (modBit)
  );

  // Pulses indexed by the wait task.
  assign pulses = {dataValid, capRate, modRate};

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Verdict and end of run, also reached from a timed-out wait.
  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [ACC_W-1:0] seen,
                       input logic [ACC_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  // Counts cycles to the next pulse, sampled at the falling edge.
  task automatic next_pulse(input int sel, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n > 5000)
      begin
        num_errors++;
        $display("ERROR pulse %0d expected within 5000 seen none", sel);
        end_sim();
      end
    end while (pulses[sel] !== 1'b1);
  endtask

  // Spacing of two later pulses; the first may follow a re-phase.
  task automatic gap(input int sel, output int n);
    next_pulse(sel, n);
    next_pulse(sel, n);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every multiplier and gain code, the clamped code 5 as well.
  task automatic t_rates();
    int n;
    int te;
    for (int t = 0; t <= 5; t++)
    begin
      te = (t > 4) ? 4 : t;
      turboSel = t[2:0];
      gainSel = 3'h0;
      gap(0, n);
      check("modGap", n, 512 >> te);
      for (int g = 0; g <= 5; g++)
      begin
        gainSel = g[2:0];
        gap(1, n);
        check("capGap", n, 512 >> (te + ((g > 4) ? 4 : g)));
      end
    end
  endtask

  // Fresh start, then word spacing, settling flag and settled value.
  task automatic t_words(input logic [1:0] pat, input logic [DR_W-1:0] dr,
                         input int exp);
    int n;
    resetn = 1'b0;
    turboSel = 3'h4;
    decimRatio = dr;
    pattern = pat;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    // First strobe comes 512/16 cycles after release; valid one cycle on.
    next_pulse(2, n);
    check("firstWord", n, 512 / 16 + 1);
    next_pulse(2, n);
    check("settledEarly", dataSettled, 1'b0);
    next_pulse(2, n);
    check("wordGap", n, 32 * (dr + 1));
    check("settled", dataSettled, 1'b1);
    repeat (2) next_pulse(2, n);
    check("word", dataWord, exp);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    resetn = 1'b0;
    turboSel = 3'h0;
    gainSel = 3'h0;
    decimRatio = 13'h0003;
    pattern = 2'h1;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_rates();
    t_words(2'h1, 13'h0003, 64);
    t_words(2'h0, 13'h0003, -64);
    t_words(2'h2, 13'h0003, 0);
    t_words(2'h1, 13'h0000, 1);
    t_words(2'h0, 13'h0007, -512);
    end_sim();
  end
endmodule // sdf_sinc3_filter_tb
`default_nettype wire
